// [hdl/swc_params.svh]
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH
// Wake source bit positions in the source vector
`define SWC_SRC_EDGE     0
`define SWC_SRC_PORTCHG  1
`define SWC_SRC_PERIPH   2
// Clock-independent peripheral source positions
`define SWC_PER_PARPORT  0
`define SWC_PER_TIMERONE 1
`define SWC_PER_CAPT     2
`define SWC_PER_SPEV     3
`define SWC_PER_SYNCBIT  4
`define SWC_PER_SYNCSLV  5
`define SWC_PER_SERSLV   6
`define SWC_PER_ADRC     7
`define SWC_PER_EEWR     8
`define SWC_PER_COUNT    9
// Interrupt vector address
`define SWC_IRQ_VECTOR   13'h0004
// Reset values of the status flags
`define SWC_TIMEOUT_RST   1'b1
`define SWC_POWERDOWN_RST 1'b1
// Oscillator start-up time in nanoseconds and clock period
`define SWC_OSC_START_NS 1000
`define SWC_CLK_NS       40
`endif

// [hdl/swc_pkg.sv]
`include "swc_params.svh"
package swc_pkg;
    typedef enum logic [4:0] {
        SWC_RUN     = 5'h01,
        SWC_SLEEP   = 5'h02,
        SWC_OSCWAIT = 5'h04,
        SWC_NEXT    = 5'h08,
        SWC_VECTOR  = 5'h10
    } swc_state_t;

    typedef struct packed {
        logic [2:0] src_flag;
        logic [2:0] src_en;
        logic [`SWC_PER_COUNT-1:0] per_flag;
        logic [`SWC_PER_COUNT-1:0] per_en;
    } swc_irq_t;

    typedef struct packed {
        swc_state_t state;
        logic       timeout_flag;
        logic       powerdown_flag;
        logic       wdt_clear;
        logic       osc_on;
        logic       hold_ports;
        logic       core_run;
        logic       dev_reset;
        logic       exec_next;
        logic       branch_vec;
        logic       sleep_nop;
        logic [15:0] osc_cnt;
    } swc_regs_t;
endpackage : swc_pkg

// [hdl/swc_sleep_wakeup.sv]
`timescale 1ns/1ps
`include "swc_params.svh"
// Functional notes
// - Sleep ends only on master clear, watchdog time-out when enabled, or an enabled interrupt.
// - Master clear in sleep resets the device; other wake sources resume without reset.
// - The power-down flag is one at power-up and cleared when sleep executes.
// - The time-out flag is cleared when a watchdog time-out wakes the device.
// - In sleep only clock-independent peripheral sources may wake the core.
// - Clock-dependent peripherals raise no interrupt while asleep.
// - The sleep instruction prefetches the instruction at the next address.
// - A source wakes the core only if its enable is set, regardless of global enable.
// - After interrupt wake the next instruction runs, then a vector branch if global enable is set.
// - A pending enabled interrupt before sleep makes sleep a no-op with no flag or watchdog change.
// - An interrupt during or after sleep lets sleep complete fully, then wakes at once.
// - Sleep entry clears watchdog and power-down, sets time-out, stops oscillator, holds ports.
// - Watchdog time-out resets when running and wakes when asleep.
module swc_sleep_wakeup #(
    parameter int OSC_START_CYC = (`SWC_OSC_START_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             master_clear_pin_i,
    input  wire logic             sleep_exec_i,
    input  wire logic             wdt_enable_i,
    input  wire logic             wdt_timeout_i,
    input  wire logic             global_irq_enable_i,
    input  wire swc_pkg::swc_irq_t irq_i,
    input  wire logic [12:0]      pc_i,
    output logic                  timeout_flag_o,
    output logic                  powerdown_flag_o,
    output logic                  wdt_clear_o,
    output logic                  osc_on_o,
    output logic                  hold_ports_o,
    output logic                  core_run_o,
    output logic                  dev_reset_o,
    output logic                  exec_next_o,
    output logic                  branch_vec_o,
    output logic                  sleep_nop_o,
    output logic [12:0]           fetch_addr_o
);
    initial begin
        if (OSC_START_CYC < 1 || OSC_START_CYC > 65535) begin
            $error("OSC_START_CYC out of range");
        end
    end

    swc_pkg::swc_regs_t st_r;
    swc_pkg::swc_regs_t st_nxt;
    logic [12:0]        fetch_r;
    logic [12:0]        fetch_nxt;
    logic               asleep;
    logic               irq_pend;
    logic               irq_wake;
    logic               wdt_wake;

    // Enabled sources; global enable is not part of the wake decision
    function automatic logic swc_pending(input swc_pkg::swc_irq_t v, input logic slp);
        logic per;
        per = |(v.per_flag & v.per_en);
        // Clock-dependent peripherals are folded into the periph bit and masked in sleep
        if (slp) begin
            return (v.src_flag[`SWC_SRC_EDGE] & v.src_en[`SWC_SRC_EDGE])
                 | (v.src_flag[`SWC_SRC_PORTCHG] & v.src_en[`SWC_SRC_PORTCHG])
                 | (per & v.src_en[`SWC_SRC_PERIPH]);
        end
        return |(v.src_flag & v.src_en) | (per & v.src_en[`SWC_SRC_PERIPH]);
    endfunction : swc_pending

    // Wake qualifiers
    assign asleep   = (st_r.state == swc_pkg::SWC_SLEEP);
    assign irq_pend = swc_pending(irq_i, 1'b0);
    assign irq_wake = swc_pending(irq_i, 1'b1);
    assign wdt_wake = wdt_enable_i & wdt_timeout_i;

    // Next-state logic
    always_comb begin
        st_nxt           = st_r;
        fetch_nxt        = fetch_r;
        st_nxt.wdt_clear = 1'b0;
        st_nxt.dev_reset = 1'b0;
        st_nxt.exec_next = 1'b0;
        st_nxt.branch_vec = 1'b0;
        st_nxt.sleep_nop = 1'b0;
        case (st_r.state)
            swc_pkg::SWC_RUN: begin
                if (wdt_wake) begin
                    st_nxt.dev_reset    = 1'b1;
                    st_nxt.timeout_flag = 1'b0;
                end else if (sleep_exec_i && irq_pend) begin
                    st_nxt.sleep_nop = 1'b1;
                end else if (sleep_exec_i) begin
                    fetch_nxt             = pc_i + 13'h0001;
                    st_nxt.wdt_clear      = 1'b1;
                    st_nxt.powerdown_flag = 1'b0;
                    st_nxt.timeout_flag   = 1'b1;
                    st_nxt.osc_on         = 1'b0;
                    st_nxt.hold_ports     = 1'b1;
                    st_nxt.core_run       = 1'b0;
                    st_nxt.state          = swc_pkg::SWC_SLEEP;
                end
            end
            swc_pkg::SWC_SLEEP: begin
                if (wdt_wake || irq_wake) begin
                    st_nxt.timeout_flag = wdt_wake ? 1'b0 : st_r.timeout_flag;
                    st_nxt.osc_on       = 1'b1;
                    st_nxt.osc_cnt      = 16'(OSC_START_CYC);
                    st_nxt.branch_vec   = 1'b0;
                    st_nxt.state        = swc_pkg::SWC_OSCWAIT;
                end
            end
            swc_pkg::SWC_OSCWAIT: begin
                if (st_r.osc_cnt <= 16'h0001) begin
                    st_nxt.osc_cnt    = 16'h0000;
                    st_nxt.core_run   = 1'b1;
                    st_nxt.hold_ports = 1'b0;
                    st_nxt.exec_next  = 1'b1;
                    st_nxt.state      = global_irq_enable_i ? swc_pkg::SWC_NEXT
                                                            : swc_pkg::SWC_RUN;
                end else begin
                    st_nxt.osc_cnt = st_r.osc_cnt - 16'h0001;
                end
            end
            swc_pkg::SWC_NEXT: begin
                st_nxt.branch_vec = 1'b1;
                fetch_nxt         = `SWC_IRQ_VECTOR;
                st_nxt.state      = swc_pkg::SWC_VECTOR;
            end
            swc_pkg::SWC_VECTOR: begin
                st_nxt.state = swc_pkg::SWC_RUN;
            end
            default: begin
                st_nxt.state = swc_pkg::SWC_RUN;
            end
        endcase
        // Master clear overrides the state, oscillator, core and port-hold controls and resets the device
        if (master_clear_pin_i) begin
            st_nxt.dev_reset  = 1'b1;
            st_nxt.state      = swc_pkg::SWC_RUN;
            st_nxt.osc_on     = 1'b1;
            st_nxt.core_run   = 1'b1;
            st_nxt.hold_ports = 1'b0;
            st_nxt.osc_cnt    = 16'h0000;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.state          <= swc_pkg::SWC_RUN;
            st_r.timeout_flag   <= `SWC_TIMEOUT_RST;
            st_r.powerdown_flag <= `SWC_POWERDOWN_RST;
            st_r.wdt_clear      <= 1'b0;
            st_r.osc_on         <= 1'b1;
            st_r.hold_ports     <= 1'b0;
            st_r.core_run       <= 1'b1;
            st_r.dev_reset      <= 1'b0;
            st_r.exec_next      <= 1'b0;
            st_r.branch_vec     <= 1'b0;
            st_r.sleep_nop      <= 1'b0;
            st_r.osc_cnt        <= 16'h0000;
            fetch_r             <= 13'h0000;
        end else begin
            st_r    <= st_nxt;
            fetch_r <= fetch_nxt;
        end
    end

    // Outputs straight from flops
    assign timeout_flag_o   = st_r.timeout_flag;
    assign powerdown_flag_o = st_r.powerdown_flag;
    assign wdt_clear_o      = st_r.wdt_clear;
    assign osc_on_o         = st_r.osc_on;
    assign hold_ports_o     = st_r.hold_ports;
    assign core_run_o       = st_r.core_run;
    assign dev_reset_o      = st_r.dev_reset;
    assign exec_next_o      = st_r.exec_next;
    assign branch_vec_o     = st_r.branch_vec;
    assign sleep_nop_o      = st_r.sleep_nop;
    assign fetch_addr_o     = fetch_r;

    // Assertions
    // Independent view of the clock-free wake sources, used only by the checks below
    logic chk_pin_wake;
    logic chk_per_wake;
    logic chk_grp_only;
    assign chk_pin_wake = (irq_i.src_flag[`SWC_SRC_EDGE] & irq_i.src_en[`SWC_SRC_EDGE])
                        | (irq_i.src_flag[`SWC_SRC_PORTCHG] & irq_i.src_en[`SWC_SRC_PORTCHG]);
    assign chk_per_wake = |(irq_i.per_flag & irq_i.per_en) & irq_i.src_en[`SWC_SRC_PERIPH];
    assign chk_grp_only = irq_i.src_flag[`SWC_SRC_PERIPH] & irq_i.src_en[`SWC_SRC_PERIPH]
                        & !chk_per_wake & !chk_pin_wake;

    // State register always holds exactly one state
    AST_STATE_ONEHOT: assert property (@(posedge clk_i) disable iff (rst_i)
        $onehot(st_r.state))
        else $error("state not one-hot");

    // Power-down flag only falls on the edge that enters sleep
    AST_PD_FALL: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(powerdown_flag_o) |-> asleep)
        else $error("power-down flag cleared outside sleep entry");

    // Clock-free peripheral with group enable wakes the core
    AST_PERIPH_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        (asleep && chk_per_wake && !master_clear_pin_i) |=> (st_r.state == swc_pkg::SWC_OSCWAIT))
        else $error("clock-free peripheral did not wake");

    // Group flag without a clock-free peripheral keeps the core asleep
    AST_GROUP_ASLEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        (asleep && chk_grp_only && !wdt_wake && !master_clear_pin_i) |=> asleep)
        else $error("clocked peripheral woke the core");

    // Sleep without a pending source always completes
    AST_SLEEP_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == swc_pkg::SWC_RUN && sleep_exec_i && !irq_pend && !wdt_wake
         && !master_clear_pin_i) |=> asleep)
        else $error("sleep did not complete");

    // While asleep the flags show a completed sleep and the clock is off
    AST_ASLEEP_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
        asleep |-> (timeout_flag_o && !powerdown_flag_o && !osc_on_o && !core_run_o
                    && hold_ports_o))
        else $error("sleep state outputs wrong");

    // Oscillator warm-up never raises a reset and never runs the core
    AST_OSCWAIT_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == swc_pkg::SWC_OSCWAIT) |-> (!dev_reset_o && !core_run_o && osc_on_o))
        else $error("warm-up outputs wrong");

    // The oscillator was already on OSC_START_CYC cycles before the resumed instruction
    AST_OSC_WARM: assert property (@(posedge clk_i) disable iff (rst_i)
        exec_next_o |-> $past(osc_on_o, OSC_START_CYC))
        else $error("core resumed before warm-up ended");

    // Without global enable the core continues and takes no vector
    AST_NO_VECTOR: assert property (@(posedge clk_i) disable iff (rst_i)
        (exec_next_o && !$past(global_irq_enable_i) && !master_clear_pin_i) |=> !branch_vec_o)
        else $error("vector taken with global enable clear");

    // With global enable the vector follows the resumed instruction
    AST_VECTOR_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
        (exec_next_o && $past(global_irq_enable_i) && !master_clear_pin_i) |=> branch_vec_o)
        else $error("vector missing after resumed instruction");

    // The resumed instruction is the one prefetched at sleep entry
    AST_RESUME_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
        exec_next_o |-> $stable(fetch_addr_o))
        else $error("prefetch address lost during sleep");

    // A no-op sleep leaves both status flags as they were
    AST_NOP_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_nop_o |-> ($stable(timeout_flag_o) && $stable(powerdown_flag_o)))
        else $error("no-op sleep changed a flag");

    AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(asleep)) |-> (!st_r.powerdown_flag && st_r.timeout_flag && !st_r.osc_on
                             && st_r.wdt_clear && st_r.hold_ports))
        else $error("sleep entry side effects missing");
    AST_NOP_SLEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == swc_pkg::SWC_RUN && sleep_exec_i && irq_pend && !wdt_wake
         && !master_clear_pin_i) |=> (sleep_nop_o && !wdt_clear_o
                                      && $stable(powerdown_flag_o) && !asleep))
        else $error("pending irq sleep not a no-op");
    AST_PREFETCH: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(asleep)) |-> (fetch_addr_o == $past(pc_i) + 13'h0001))
        else $error("prefetch address wrong");
    AST_MASTER_CLEAR_PIN_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
        master_clear_pin_i |=> (dev_reset_o && st_r.state == swc_pkg::SWC_RUN))
        else $error("master clear did not reset");
    AST_WDT_RUN_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == swc_pkg::SWC_RUN && wdt_wake) |=> dev_reset_o)
        else $error("run-mode watchdog did not reset");
    AST_WDT_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        (asleep && wdt_wake && !master_clear_pin_i) |=> (!timeout_flag_o && !dev_reset_o
                                                        && st_r.state == swc_pkg::SWC_OSCWAIT))
        else $error("watchdog wake wrong");
    AST_STAY_ASLEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        (asleep && !wdt_wake && !irq_wake && !master_clear_pin_i) |=> asleep)
        else $error("spurious wake");
    AST_IRQ_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        (asleep && irq_wake && !master_clear_pin_i) |=> (osc_on_o && !core_run_o))
        else $error("enabled irq did not wake");
    AST_OSC_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(core_run_o) && !$past(master_clear_pin_i) |-> $past(osc_on_o, 1))
        else $error("core resumed before oscillator");
    AST_VECTOR: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.state == swc_pkg::SWC_NEXT && !master_clear_pin_i) |=>
        (branch_vec_o && fetch_addr_o == `SWC_IRQ_VECTOR))
        else $error("vector branch missing");

    COV_SLEEP_WDT: cover property (@(posedge clk_i) disable iff (rst_i)
        asleep ##1 st_r.state == swc_pkg::SWC_OSCWAIT && !timeout_flag_o);
    COV_IRQ_VEC: cover property (@(posedge clk_i) disable iff (rst_i)
        st_r.state == swc_pkg::SWC_NEXT ##1 branch_vec_o);
    COV_NOP: cover property (@(posedge clk_i) disable iff (rst_i) sleep_nop_o);
    COV_MASTER_CLEAR_PIN_SLEEP: cover property (@(posedge clk_i) disable iff (rst_i)
        asleep && master_clear_pin_i);
    COV_GIE_OFF: cover property (@(posedge clk_i) disable iff (rst_i)
        exec_next_o && !$past(global_irq_enable_i));
endmodule : swc_sleep_wakeup

// [test/swc_src_model.sv]
`timescale 1ns/1ps
// Interrupt sources: every flag can rise, only the selected source is enabled
module swc_src_model (
    input  wire logic [3:0]   src_sel_i,
    input  wire logic         fire_i,
    input  wire logic         enable_i,
    input  wire logic [11:0]  noise_i,
    output swc_pkg::swc_irq_t irq_o
);
    // Noise lands on unenabled flags; selected source carries fire and enable
    always_comb begin
        irq_o = '0;
        irq_o.src_flag = noise_i[2:0];
        irq_o.per_flag = noise_i[11:3];
        if (src_sel_i < 4'h2) begin
            irq_o.src_flag[src_sel_i[0]] = fire_i;
            irq_o.src_en[src_sel_i[0]] = enable_i;
        end else begin
            irq_o.src_flag[2] = fire_i;
            irq_o.src_en[2] = enable_i;
            irq_o.per_flag[src_sel_i - 4'h2] = fire_i;
            irq_o.per_en[src_sel_i - 4'h2] = enable_i;
        end
    end
endmodule : swc_src_model

// [test/sleep_wakeup_control_tb_top.sv]
`timescale 1ns/1ps
module sleep_wakeup_control_tb_top;
    logic              clk_i, rst_i, master_clear_pin_i, sleep_exec_i, wdt_enable_i;
    logic              wdt_timeout_i, global_irq_enable_i, fire, enable, exp_to, exp_pd;
    logic              timeout_flag_o, powerdown_flag_o, wdt_clear_o, osc_on_o, hold_ports_o;
    logic              core_run_o, dev_reset_o, exec_next_o, branch_vec_o, sleep_nop_o;
    logic [3:0]        src_sel;
    logic [11:0]       noise;
    logic [12:0]       pc_i, fetch_addr_o;
    logic [19:0]       mon_e;
    logic [19:0]       notes[$];
    swc_pkg::swc_irq_t irq_i;
    int                n_mismatch = 0;
    int                samples_checked = 0;
    int                seed = 32'hd665;

    swc_src_model PART (.src_sel_i(src_sel), .fire_i(fire), .enable_i(enable),
        .noise_i(noise), .irq_o(irq_i));
    swc_sleep_wakeup #(.OSC_START_CYC(2)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .master_clear_pin_i(master_clear_pin_i), .sleep_exec_i(sleep_exec_i),
        .wdt_enable_i(wdt_enable_i), .wdt_timeout_i(wdt_timeout_i),
        .global_irq_enable_i(global_irq_enable_i), .irq_i(irq_i), .pc_i(pc_i),
        .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
        .wdt_clear_o(wdt_clear_o), .osc_on_o(osc_on_o), .hold_ports_o(hold_ports_o),
        .core_run_o(core_run_o), .dev_reset_o(dev_reset_o), .exec_next_o(exec_next_o),
        .branch_vec_o(branch_vec_o), .sleep_nop_o(sleep_nop_o), .fetch_addr_o(fetch_addr_o));

    task check(input logic [18:0] seen, input logic [18:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Expected pulse kind {nop, next, reset, vector}, flags and optional fetch address
    task note(input logic [3:0] kind, input logic chk, input logic [12:0] fa);
        notes.push_back({chk, kind, exp_to, exp_pd, fa});
    endtask : note
    task cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task sleep_at(input logic [12:0] p);
        @(negedge clk_i);
        sleep_exec_i = 1'b1;
        pc_i = p;
        @(negedge clk_i);
        sleep_exec_i = 1'b0;
    endtask : sleep_at
    // Bounded wait for the core to run again
    task wait_run;
        int i;
        for (i = 0; i < 40 && core_run_o !== 1'b1; i++) @(negedge clk_i);
        if (core_run_o !== 1'b1) n_mismatch++;
        cyc(3);
    endtask : wait_run
    task complete_run;
        $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Hang guard, far beyond the few hundred cycles of the sequence
    initial begin
        #(40 * 20000);
        n_mismatch++;
        complete_run();
    end
    // Monitor: each output pulse takes the oldest note
    always @(negedge clk_i) begin
        if (!rst_i && (sleep_nop_o | exec_next_o | dev_reset_o | branch_vec_o) === 1'b1) begin
            mon_e = (notes.size() > 0) ? notes.pop_front() : '1;
            check({sleep_nop_o, exec_next_o, dev_reset_o, branch_vec_o, timeout_flag_o,
                powerdown_flag_o, mon_e[19] ? fetch_addr_o : mon_e[12:0]}, mon_e[18:0]);
        end
    end

    initial begin
        int k;
        logic [12:0] p;
        rst_i = 1'b1;
        master_clear_pin_i = 1'b0;
        sleep_exec_i = 1'b0;
        wdt_enable_i = 1'b0;
        wdt_timeout_i = 1'b0;
        global_irq_enable_i = 1'b0;
        pc_i = 13'h0;
        fire = 1'b0;
        enable = 1'b0;
        src_sel = 4'h0;
        noise = 12'h0;
        exp_to = 1'b1;
        exp_pd = 1'b1;
        cyc(10);
        rst_i = 1'b0;
        cyc(1);
        check({timeout_flag_o, powerdown_flag_o}, 19'h3);
        // Enabled flag already pending: sleep becomes a no-op
        noise = 12'($random(seed));
        enable = 1'b1;
        fire = 1'b1;
        note(4'h8, 1'b0, 13'h0);
        sleep_at(13'h0100);
        cyc(3);
        fire = 1'b0;
        // Every interrupt wake source, random address and global enable
        for (k = 0; k < 11; k++) begin
            p = 13'($random(seed));
            src_sel = 4'(k);
            global_irq_enable_i = 1'($random(seed));
            noise = 12'($random(seed));
            sleep_at(p);
            exp_pd = 1'b0;
            cyc(3);
            note(4'h4, 1'b1, p + 13'h1);
            if (global_irq_enable_i) note(4'h1, 1'b1, 13'h0004);
            fire = 1'b1;
            wait_run();
            fire = 1'b0;
        end
        // Unenabled flag and disabled watchdog must not wake; enabled watchdog does
        global_irq_enable_i = 1'b0;
        enable = 1'b0;
        fire = 1'b1;
        sleep_at(13'h0200);
        cyc(5);
        // Group flag noise is overridden by the low fire of source 10, so no flag rises here
        enable = 1'b1;
        fire = 1'b0;
        noise = 12'h004;
        cyc(3);
        enable = 1'b0;
        fire = 1'b1;
        noise = 12'h000;
        wdt_timeout_i = 1'b1;
        cyc(1);
        wdt_timeout_i = 1'b0;
        cyc(5);
        exp_to = 1'b0;
        note(4'h4, 1'b1, 13'h0201);
        wdt_enable_i = 1'b1;
        wdt_timeout_i = 1'b1;
        cyc(1);
        wdt_timeout_i = 1'b0;
        wait_run();
        fire = 1'b0;
        // Master clear while asleep
        sleep_at(13'h0300);
        exp_to = 1'b1;
        cyc(3);
        note(4'h2, 1'b0, 13'h0);
        master_clear_pin_i = 1'b1;
        cyc(1);
        master_clear_pin_i = 1'b0;
        cyc(5);
        // Second reset, then watchdog in run wins over a sleep in the same cycle
        rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        cyc(2);
        exp_to = 1'b0;
        exp_pd = 1'b1;
        note(4'h2, 1'b0, 13'h0);
        sleep_exec_i = 1'b1;
        wdt_timeout_i = 1'b1;
        cyc(1);
        sleep_exec_i = 1'b0;
        wdt_timeout_i = 1'b0;
        cyc(5);
        check({powerdown_flag_o, osc_on_o}, 19'h3);
        check(19'(notes.size()), 19'h0);
        complete_run();
    end
endmodule : sleep_wakeup_control_tb_top
